/* logic/twrt_pkg.sv */
// constants, states and carriers of the two-wire register target
package twrt_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h36;
  localparam logic [7:0] WR_LIMIT = 8'h4f;
  localparam logic [7:0] RD_FILL = 8'hff;
  localparam logic [7:0] PTR_END = 8'hff;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_RD_BIT = 4'h7;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_MACK
  } twrt_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } twrt_pins_s;

  // one complete register write: even byte address, msb then lsb
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } twrt_wr_s;

  localparam int WR_W = $bits(twrt_wr_s);
endpackage : twrt_pkg

/* logic/twrt_target.sv */
// two-wire register target with its write fifo
// How it works
// - target only: no clock output, never makes START or STOP.
// - any bus rate up to 400kHz, no speed setting.
// - data pin input while receiving, driven only low when answering.
// - one bit per clock; data change while clock high is START/STOP.
// - repeated START ends the transaction and begins a new one.
// - acknowledge: data low before ninth rise, held until clock falls.
// - not-acknowledge: data released before ninth rise, until clock falls.
// - bytes are eight bits msb first, then the acknowledge bit.
// - register msb byte at even address, lsb at next odd address.
// - watch for START plus own address; acknowledge after direction bit.
// - fixed address 0110110, first byte 6Ch write, 6Dh read.
// - direction zero is a write, direction one is a read.
// - write: address, pointer byte, data bytes, each acknowledged unless it completes a writable pair while the write fifo is full, stored from pointer.
// - read: pointer write, repeated START, read address; target answers.
// - target drives read bytes; master not-acknowledge makes target release.
// - every byte is acknowledged before the next one moves.
// - idle when both lines high; STOP returns the bus to idle.
// - pointer advances after each data byte received or sent, except a byte refused by a full fifo.
// - writes past 4Fh or to locked addresses ignored; pairs only stored.
// - incomplete or not-acknowledged bytes are never stored.
// - reads past FFh return FFh.
`timescale 1ns/1ps

module twrt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] wp_next;
  logic [AW:0] rp_reg;
  logic [AW:0] rp_next;
  logic full;
  logic empty;
  logic do_wr;

  always_comb
  begin
    empty = (wp_reg == rp_reg);
    full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    do_wr = in_valid_i && !full;
    wp_next = do_wr ? wp_reg + {{AW{1'b0}}, 1'b1} : wp_reg;
    rp_next = (out_ready_i && !empty) ? rp_reg + {{AW{1'b0}}, 1'b1} : rp_reg;
  end

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_reg[rp_reg[AW-1:0]];

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else if (ce_i)
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // storage has no reset: only entries below the write pointer are read
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && do_wr)
    begin
      mem_reg[wp_reg[AW-1:0]] <= in_data_i;
    end
  end
endmodule : twrt_fifo

module twrt_target (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic wr_lock_i,
  output twrt_pkg::twrt_wr_s wr_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic busy_o
);
  twrt_pkg::twrt_pins_s meta_reg, meta_next;
  twrt_pkg::twrt_pins_s sync_reg, sync_next;
  twrt_pkg::twrt_pins_s prev_reg, prev_next;
  twrt_pkg::twrt_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic ovf_reg, ovf_next;
  logic rw_reg, rw_next;
  logic drive_reg, drive_next;
  logic ack_reg, ack_next;
  logic [7:0] msb_reg, msb_next;
  logic msb_ok_reg, msb_ok_next;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic push, fifo_ready;
  logic [7:0] rd_byte;
  twrt_pkg::twrt_wr_s push_data;

  function automatic logic writable(input logic [7:0] a, input logic lock, input logic ovf);
    writable = !ovf && !lock && (a <= twrt_pkg::WR_LIMIT);
  endfunction : writable

  // pointer sticks in overflow once it has passed the top address
  function automatic logic [8:0] ptr_step(input logic [7:0] p, input logic ovf);
    ptr_step = {ovf | (p == twrt_pkg::PTR_END), p + twrt_pkg::PTR_STEP};
  endfunction : ptr_step

  always_comb
  begin
    // edges compare the second stage with the third, the first is metastable
    scl_rise = sync_reg.scl && !prev_reg.scl;
    scl_fall = !sync_reg.scl && prev_reg.scl;
    start_det = sync_reg.scl && prev_reg.scl && prev_reg.sda && !sync_reg.sda;
    stop_det = sync_reg.scl && prev_reg.scl && !prev_reg.sda && sync_reg.sda;
    rd_byte = ovf_reg ? twrt_pkg::RD_FILL : rd_data_i;
  end

  always_comb
  begin
    // three samples per edge are ample at 125 core clocks per 400kHz bit
    meta_next = '{scl: scl_i, sda: sda_i};
    sync_next = meta_reg;
    prev_next = sync_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    ovf_next = ovf_reg;
    rw_next = rw_reg;
    drive_next = drive_reg;
    ack_next = ack_reg;
    msb_next = msb_reg;
    msb_ok_next = msb_ok_reg;
    push = 1'b0;
    push_data = '{addr: {ptr_reg[7:1], 1'b0}, data: {msb_reg, sh_reg}};
    if (start_det)
    begin
      state_next = twrt_pkg::ST_ADDR;
      cnt_next = '0;
      drive_next = 1'b0;
      msb_ok_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = twrt_pkg::ST_IDLE;
      drive_next = 1'b0;
      msb_ok_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        twrt_pkg::ST_ADDR, twrt_pkg::ST_PTR, twrt_pkg::ST_WDATA:
        begin
          if (scl_rise)
          begin
            sh_next = {sh_reg[6:0], sync_reg.sda};
            cnt_next = cnt_reg + twrt_pkg::CNT_STEP;
          end
          else if (scl_fall && cnt_reg == twrt_pkg::BYTE_BITS)
          begin
            cnt_next = '0;
            drive_next = 1'b1;
            if (state_reg == twrt_pkg::ST_ADDR)
            begin
              if (sh_reg[7:1] == twrt_pkg::TARGET_ADDR)
              begin
                state_next = twrt_pkg::ST_AACK;
                rw_next = sh_reg[0];
              end
              else
              begin
                state_next = twrt_pkg::ST_IDLE;
                drive_next = 1'b0;
              end
            end
            else if (state_reg == twrt_pkg::ST_PTR)
            begin
              state_next = twrt_pkg::ST_PACK;
              ptr_next = sh_reg;
              ovf_next = 1'b0;
            end
            else
            begin
              state_next = twrt_pkg::ST_WACK;
              {ovf_next, ptr_next} = ptr_step(ptr_reg, ovf_reg);
              if (!ptr_reg[0])
              begin
                msb_next = sh_reg;
                msb_ok_next = writable(ptr_reg, wr_lock_i, ovf_reg);
              end
              else
              begin
                msb_ok_next = 1'b0;
                if (msb_ok_reg && writable(ptr_reg, wr_lock_i, ovf_reg))
                begin
                  if (fifo_ready)
                  begin
                    push = 1'b1;
                  end
                  else
                  begin
                    // no clock stretching: a full fifo is refused with a not-acknowledge
                    drive_next = 1'b0;
                    ptr_next = ptr_reg;
                    ovf_next = ovf_reg;
                  end
                end
              end
            end
          end
        end
        twrt_pkg::ST_AACK, twrt_pkg::ST_PACK, twrt_pkg::ST_WACK:
        begin
          if (scl_fall)
          begin
            drive_next = 1'b0;
            cnt_next = '0;
            if (state_reg == twrt_pkg::ST_AACK && rw_reg)
            begin
              state_next = twrt_pkg::ST_RDATA;
              sh_next = rd_byte;
              drive_next = !rd_byte[7];
            end
            else if (!drive_reg)
            begin
              state_next = twrt_pkg::ST_IDLE;
            end
            else if (state_reg == twrt_pkg::ST_AACK)
            begin
              state_next = twrt_pkg::ST_PTR;
            end
            else
            begin
              state_next = twrt_pkg::ST_WDATA;
            end
          end
        end
        twrt_pkg::ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == twrt_pkg::LAST_RD_BIT)
            begin
              state_next = twrt_pkg::ST_MACK;
              drive_next = 1'b0;
              cnt_next = '0;
              {ovf_next, ptr_next} = ptr_step(ptr_reg, ovf_reg);
            end
            else
            begin
              cnt_next = cnt_reg + twrt_pkg::CNT_STEP;
              sh_next = {sh_reg[6:0], 1'b1};
              drive_next = !sh_reg[6];
            end
          end
        end
        twrt_pkg::ST_MACK:
        begin
          if (scl_rise)
          begin
            ack_next = !sync_reg.sda;
          end
          else if (scl_fall)
          begin
            if (ack_reg)
            begin
              state_next = twrt_pkg::ST_RDATA;
              sh_next = rd_byte;
              drive_next = !rd_byte[7];
            end
            else
            begin
              state_next = twrt_pkg::ST_IDLE;
            end
          end
        end
        twrt_pkg::ST_IDLE:
        begin
          drive_next = 1'b0;
        end
        default:
        begin
          state_next = twrt_pkg::ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
      state_reg <= twrt_pkg::ST_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      ptr_reg <= '0;
      ovf_reg <= 1'b0;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      ack_reg <= 1'b0;
      msb_reg <= '0;
      msb_ok_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      ovf_reg <= ovf_next;
      rw_reg <= rw_next;
      drive_reg <= drive_next;
      ack_reg <= ack_next;
      msb_reg <= msb_next;
      msb_ok_reg <= msb_ok_next;
    end
  end

  twrt_fifo #(
    .WIDTH(twrt_pkg::WR_W),
    .DEPTH(twrt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_o)
  );

  // the pin only ever pulls low; the pull-up makes the high level
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !drive_reg;
  assign rd_addr_o = ptr_reg;
  assign busy_o = (state_reg != twrt_pkg::ST_IDLE);

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  addr_match_a: assert property ((state_reg == twrt_pkg::ST_AACK && $past(state_reg) != twrt_pkg::ST_AACK) |-> $past(sh_reg[7:1]) == twrt_pkg::TARGET_ADDR)
    else $error("address acknowledged without a match");
  idle_release_a: assert property (state_reg == twrt_pkg::ST_IDLE |-> sda_oe_n_o)
    else $error("data line driven while idle");
  start_abort_a: assert property ((ce_i && start_det) |=> state_reg == twrt_pkg::ST_ADDR && cnt_reg == '0 && sda_oe_n_o)
    else $error("start did not restart address phase");
  stop_idle_a: assert property ((ce_i && stop_det && !start_det) |=> state_reg == twrt_pkg::ST_IDLE && sda_oe_n_o)
    else $error("stop did not return to idle");
  ptr_advance_a: assert property ((ce_i && state_reg == twrt_pkg::ST_RDATA && scl_fall && !start_det && !stop_det && cnt_reg == twrt_pkg::LAST_RD_BIT) |=> ptr_reg == $past(ptr_reg) + twrt_pkg::PTR_STEP && state_reg == twrt_pkg::ST_MACK)
    else $error("pointer did not advance after read byte");
  pair_even_a: assert property (push |-> push_data.addr[0] == 1'b0 && ptr_reg[0] && msb_ok_reg)
    else $error("register pair stored at odd address");
  write_limit_a: assert property (push |-> push_data.addr < twrt_pkg::WR_LIMIT && !wr_lock_i && !ovf_reg)
    else $error("write stored beyond limit or to locked address");
  fill_read_a: assert property ((state_reg == twrt_pkg::ST_RDATA && $past(state_reg) != twrt_pkg::ST_RDATA && $past(ovf_reg)) |-> sh_reg == twrt_pkg::RD_FILL)
    else $error("read past top did not return fill value");
  msb_first_a: assert property (state_reg == twrt_pkg::ST_RDATA |-> sda_oe_n_o == sh_reg[7])
    else $error("read bit does not follow msb first order");
  nak_release_a: assert property ((state_reg == twrt_pkg::ST_MACK && ce_i && scl_fall && !ack_reg && !start_det && !stop_det) |=> state_reg == twrt_pkg::ST_IDLE ##1 sda_oe_n_o)
    else $error("target kept the line after not-acknowledge");
  ack_hold_a: assert property (($rose(drive_reg) && state_reg == twrt_pkg::ST_WACK) |-> !sda_oe_n_o && !scl_rise)
    else $error("acknowledge not set up before clock rise");
endmodule : twrt_target

/* tb/twrt_master_model.sv */
// two-wire bus master model that drives the target's pins
`timescale 1ns/1ps
module twrt_master_model #(
  parameter int LOW_NS = 100,
  parameter int HIGH_NS = 60
) (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // 1 releases a line, the pull-up on the wire then makes it high
  initial
  begin
    scl_o = 1'b1; // both lines high while idle
    sda_o = 1'b1;
  end

  // from idle, or with the clock low as a repeated start
  task automatic bus_start();
    sda_o = 1'b1;
    #LOW_NS;
    scl_o = 1'b1;
    #HIGH_NS;
    sda_o = 1'b0;
    #HIGH_NS;
    scl_o = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    sda_o = 1'b0;
    #LOW_NS;
    scl_o = 1'b1;
    #HIGH_NS;
    sda_o = 1'b1;
    #HIGH_NS;
  endtask : bus_stop

  // data moves early in the low phase so a late release by the target settles first
  task automatic clk_bit(input logic b, output logic seen);
    #(LOW_NS * 2 / 5);
    sda_o = b;
    #(LOW_NS * 3 / 5);
    scl_o = 1'b1;
    // sample a third into the high phase, clear of the core clock's rising edge
    #(HIGH_NS / 3);
    seen = sda_i;
    #(HIGH_NS - HIGH_NS / 3);
    scl_o = 1'b0;
  endtask : clk_bit

  task automatic put_bits(input logic [7:0] d, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--)
    begin
      clk_bit(d[i], s);
    end
  endtask : put_bits

  // the line is let go for the answer only
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    put_bits(d, 8);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // more low refuses the last byte so the target hands the line back
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~more, s);
  endtask : get_byte
endmodule : twrt_master_model

/* tb/twrt_target_bench.sv */
// self-checking bench of the two-wire register target
`timescale 1ns/1ps
module twrt_target_bench;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic [7:0] ab;
    logic [7:0] ptr;
    logic [15:0] data;
    logic acked;
    logic stored;
  } twrt_row_s;
  logic clk;
  logic resetn;
  logic ce;
  logic scl;
  logic m_sda;
  logic sda_dev;
  logic sda_oe_n;
  logic sda_line;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_lock;
  logic wr_valid;
  logic wr_ready;
  logic busy;
  logic ack;
  logic [7:0] got;
  twrt_pkg::twrt_wr_s wr;
  twrt_row_s rows [6];
  logic [7:0] ptrs [2];
  int a;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  // wired-and line with pull-up
  assign sda_line = m_sda & (sda_oe_n | sda_dev);
  assign rd_data = rd_addr ^ 8'h5a;
  // addresses 10h and 11h act as read-only
  assign wr_lock = (rd_addr[7:1] == 7'h08);

  twrt_target dut (.core_clk_i(clk), .resetn_i(resetn), .ce_i(ce), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .wr_lock_i(wr_lock), .wr_o(wr), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .busy_o(busy));
  twrt_master_model m (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_line));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk_byte

  task automatic chk_word(input string n, input twrt_pkg::twrt_wr_s e,
    input twrt_pkg::twrt_wr_s g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk_word

  task automatic send(input logic [7:0] b, input logic exp);
    m.put_byte(b, ack);
    chk_bit("ack", exp, ack);
  endtask : send

  // stop detection needs the synchroniser delay plus one clock
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle

  task automatic pop_chk(input twrt_pkg::twrt_wr_s e);
    chk_bit("wr_valid", 1'b1, wr_valid);
    chk_word("wr", e, wr);
    wr_ready = 1'b1;
    @(negedge clk);
    wr_ready = 1'b0;
    // a gap keeps a following pop from raising ready in the same time step
    @(negedge clk);
  endtask : pop_chk

  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    wr_ready = 1'b0;
    rows[0] = '{8'h6c, 8'h02, 16'ha55a, 1'b1, 1'b1};
    rows[1] = '{8'h6c, 8'h4e, 16'h1234, 1'b1, 1'b1};
    rows[2] = '{8'h6c, 8'h4f, 16'hbeef, 1'b1, 1'b0};
    rows[3] = '{8'h6c, 8'h50, 16'hc3c3, 1'b1, 1'b0};
    rows[4] = '{8'h6e, 8'h02, 16'h0000, 1'b0, 1'b0};
    rows[5] = '{8'h6c, 8'h10, 16'h7777, 1'b1, 1'b0};
    ptrs[0] = 8'h20;
    ptrs[1] = 8'hfe;
    repeat (5) @(negedge clk);
    chk_bit("oe_n", 1'b1, sda_oe_n);
    chk_bit("busy", 1'b0, busy);
    chk_bit("wr_valid", 1'b0, wr_valid);
    chk_byte("pointer", 8'h00, rd_addr);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[k])
    begin
      m.bus_start();
      send(rows[k].ab, rows[k].acked);
      if (rows[k].acked)
      begin
        send(rows[k].ptr, 1'b1);
        send(rows[k].data[15:8], 1'b1);
        send(rows[k].data[7:0], 1'b1);
      end
      m.bus_stop();
      settle();
      chk_bit("busy", 1'b0, busy);
      chk_bit("wr_valid", rows[k].stored, wr_valid);
      if (rows[k].acked) chk_byte("pointer", rows[k].ptr + 8'h02, rd_addr);
      if (rows[k].stored) pop_chk({rows[k].ptr, rows[k].data});
    end
    m.bus_start();
    send(8'h6c, 1'b1);
    m.bus_stop();
    settle();
    chk_bit("busy", 1'b0, busy);
    // with the clock enable low the whole target is frozen and must not answer
    ce = 1'b0;
    m.bus_start();
    send(8'h6c, 1'b0);
    ce = 1'b1;
    m.bus_stop();
    settle();
    chk_bit("busy", 1'b0, busy);
    foreach (ptrs[p])
    begin
      m.bus_start();
      send(8'h6c, 1'b1);
      send(ptrs[p], 1'b1);
      m.bus_start();
      send(8'h6d, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
        m.get_byte(i < 2, got);
        a = ptrs[p] + i;
        chk_byte("rd", (a > 255) ? 8'hff : 8'(a) ^ 8'h5a, got);
      end
      m.bus_stop();
      settle();
      chk_bit("oe_n", 1'b1, sda_oe_n);
      chk_byte("pointer", ptrs[p] + 8'h03, rd_addr);
    end
    m.bus_start();
    send(8'h6c, 1'b1);
    send(8'h20, 1'b1);
    for (int i = 0; i < 17; i++)
    begin
      send(8'h80 + 8'(i), 1'b1);
    end
    send(8'h91, 1'b0);
    m.bus_stop();
    settle();
    chk_byte("pointer", 8'h31, rd_addr);
    for (int i = 0; i < 8; i++)
    begin
      pop_chk({8'h20 + 8'(2 * i), 8'h80 + 8'(2 * i), 8'h81 + 8'(2 * i)});
    end
    chk_bit("wr_valid", 1'b0, wr_valid);
    m.bus_start();
    send(8'h6c, 1'b1);
    send(8'h30, 1'b1);
    send(8'h90, 1'b1);
    send(8'h91, 1'b1);
    m.bus_stop();
    settle();
    pop_chk({8'h30, 8'h90, 8'h91});
    // read straight away with the pointer left by the write above
    m.bus_start();
    send(8'h6d, 1'b1);
    m.get_byte(1'b0, got);
    chk_byte("rd", 8'h32 ^ 8'h5a, got);
    m.bus_stop();
    settle();
    m.bus_start();
    send(8'h6c, 1'b1);
    send(8'h40, 1'b1);
    send(8'h11, 1'b1);
    m.put_bits(8'h22, 4);
    m.bus_start();
    send(8'h6c, 1'b1);
    m.bus_stop();
    settle();
    chk_bit("wr_valid", 1'b0, wr_valid);
    chk_bit("oe_n", 1'b1, sda_oe_n);
    report_and_stop();
  end
endmodule : twrt_target_bench
